//--- pkg/rpm_defines.svh
// Register offsets, field positions and reset values of the receiver power and secondary mux bank
`ifndef RPM_DEFINES_SVH
`define RPM_DEFINES_SVH

`define RPM_ADDR_PWR_DOWN   8'h15
`define RPM_ADDR_RSV_16     8'h16
`define RPM_ADDR_RSV_17     8'h17
`define RPM_ADDR_SEC_SEL    8'h18
`define RPM_ADDR_RSV_19     8'h19
`define RPM_ADDR_RSV_1A     8'h1A
`define RPM_ADDR_RSV_1B     8'h1B
`define RPM_ADDR_RATE_SEL   8'h1C

`define RPM_RST_PWR_DOWN    8'h00
`define RPM_RST_RSV_16      8'h7A
`define RPM_RST_RSV_17      8'h36
`define RPM_RST_SEC_SEL     8'h00
`define RPM_RST_RSV_19      8'h3C
`define RPM_RST_RSV_1A      8'h00
`define RPM_RST_RSV_1B      8'h03
`define RPM_RST_RATE_SEL    8'h64
`define RPM_UNMAPPED_DATA   8'h00

`define RPM_EQ_PD_LSB       0
`define RPM_DET_PD_LSB      4
`define RPM_SEC_SEL_LSB     0
`define RPM_RATE_LSB        0

`define RPM_CODE_IN0        2'h0
`define RPM_CODE_IN1        2'h1
`define RPM_CODE_IN2        2'h2
`define RPM_CODE_IN3        2'h3
`define RPM_EQ_CHOICE_RST   1'h1

`endif

//--- pkg/rpm_pkg.sv
// Types shared by the receiver power and secondary mux bank
`default_nettype none

package rpm_pkg;

    typedef struct packed {
        logic [7:0] pwr_down;
        logic [7:0] rsv_16;
        logic [7:0] rsv_17;
        logic [7:0] sec_sel;
        logic [7:0] rsv_19;
        logic [7:0] rsv_1a;
        logic [7:0] rsv_1b;
        logic [7:0] rate_sel;
        logic [7:0] rdata;
        logic       rvalid;
    } rpm_regs_type;

    typedef struct packed {
        logic [1:0] channel;
        logic       use_equalized;
    } rpm_route_type;

endpackage

`default_nettype wire

//--- pkg/rpm_route_if.sv
// Signals between the register bank and the secondary path router
`timescale 1ns/1ps
`default_nettype none

interface rpm_route_if;
    logic [1:0] secondary_channel_select;
    logic       secondary_select_override;
    logic [1:0] primary_channel_select;
    logic       secondary_equalized_choice;
    logic [1:0] routed_channel;
    logic       routed_equalized;

    modport bank (
        output secondary_channel_select,
        output secondary_select_override,
        output primary_channel_select,
        output secondary_equalized_choice,
        input  routed_channel,
        input  routed_equalized
    );

    modport router (
        input  secondary_channel_select,
        input  secondary_select_override,
        input  primary_channel_select,
        input  secondary_equalized_choice,
        output routed_channel,
        output routed_equalized
    );
endinterface

`default_nettype wire

//--- rtl/rpm_route.sv
// Secondary path router: picks the channel feeding eye monitor and output 1 bypass
`timescale 1ns/1ps
`include "rpm_defines.svh"
`default_nettype none

module rpm_route (
    input  wire logic    clock,
    input  wire logic    reset,
    rpm_route_if.router  rif
);

    rpm_pkg::rpm_route_type state_ff;
    rpm_pkg::rpm_route_type nxt_state;

    // Code 01 taken as input 1; the printed table repeats input 2 there
    function automatic logic [1:0] sec_decode(input logic [1:0] code);
        case (code)
            `RPM_CODE_IN0: sec_decode = `RPM_CODE_IN0;
            `RPM_CODE_IN1: sec_decode = `RPM_CODE_IN1;
            `RPM_CODE_IN2: sec_decode = `RPM_CODE_IN2;
            default:       sec_decode = `RPM_CODE_IN3;
        endcase
    endfunction

    always_comb begin
        nxt_state = state_ff;
        if (rif.secondary_select_override) begin
            nxt_state.channel = sec_decode(rif.secondary_channel_select);
        end else begin
            nxt_state.channel = rif.primary_channel_select;
        end
        nxt_state.use_equalized = rif.secondary_equalized_choice;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff.channel       <= `RPM_CODE_IN0;
            state_ff.use_equalized <= `RPM_EQ_CHOICE_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rif.routed_channel   = state_ff.channel;
    assign rif.routed_equalized = state_ff.use_equalized;

    ////////////////////////////////////////////////////////////////////////////
    AST_SEC_OVERRIDE_ROUTE:
    assert property (@(posedge clock) disable iff (reset)
        rif.secondary_select_override && rif.secondary_channel_select == 2'h3
        |=> rif.routed_channel == 2'h3)
    else $error("override set but secondary code 3 not routed");

    AST_SEC_DECODE_ONE:
    assert property (@(posedge clock) disable iff (reset)
        rif.secondary_select_override && rif.secondary_channel_select == 2'h1
        |=> rif.routed_channel == 2'h1)
    else $error("secondary code 1 did not route input 1");

    AST_SEC_DECODE_TWO:
    assert property (@(posedge clock) disable iff (reset)
        rif.secondary_select_override && rif.secondary_channel_select == 2'h2
        |=> rif.routed_channel == 2'h2)
    else $error("secondary code 2 did not route input 2");

    AST_PRIMARY_FOLLOW:
    assert property (@(posedge clock) disable iff (reset)
        !rif.secondary_select_override
        |=> rif.routed_channel == $past(rif.primary_channel_select))
    else $error("override clear but primary selection not followed");

    AST_EQ_CHOICE:
    assert property (@(posedge clock) disable iff (reset)
        rif.secondary_equalized_choice ##1 !rif.secondary_equalized_choice
        |-> rif.routed_equalized ##1 !rif.routed_equalized)
    else $error("equalized choice not passed to secondary path");

endmodule // rpm_route

`default_nettype wire

//--- rtl/rpm_top.sv
// Receiver power-down and secondary input select register bank
// What this block does
// - Bit 5 of power-down register powers down input 1 detector; resets 0.
// - Bit 4 of power-down register powers down input 0 detector; resets 0.
// - Bit 3 of power-down register powers down input 3 equalizer; resets 0.
// - Bit 2 of power-down register powers down input 2 equalizer; resets 0.
// - Bit 1 of power-down register powers down input 1 equalizer; resets 0.
// - Bit 0 of power-down register powers down input 0 equalizer; resets 0.
// - Two-bit secondary select, reset 00, steers paths only while override set.
// - Secondary codes 00,01,10,11 pick inputs 0,1,2,3.
// - Secondary select bits 7:2 are reserved, read-write, reset zero.
// - With override clear, secondary paths follow the primary input selection.
// - Bits 7 and 6 power down detectors of inputs 3 and 2; reset 0.
// - Equalized choice bit, default 1, picks equalized or raw secondary data.
`timescale 1ns/1ps
`include "rpm_defines.svh"
`default_nettype none

module rpm_top (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    input  wire logic       secondary_select_override,
    input  wire logic       secondary_equalized_choice,
    input  wire logic [1:0] primary_channel_select,
    input  wire logic [3:0] detector_signal_raw,
    output logic      [3:0] equalizer_power_down,
    output logic      [3:0] detector_power_down,
    output logic      [3:0] signal_present,
    output logic      [1:0] eye_monitor_channel,
    output logic      [1:0] serial_output_1_bypass_channel,
    output logic            secondary_use_equalized,
    output logic      [1:0] line_rate_code
);

    rpm_pkg::rpm_regs_type regs_ff;
    rpm_pkg::rpm_regs_type nxt_regs;
    rpm_route_if           route_bus ();

    // Read mux; unmapped offsets answer zero so software sees a defined value
    function automatic logic [7:0] read_mux(input rpm_pkg::rpm_regs_type r,
                                            input logic [7:0] addr);
        case (addr)
            `RPM_ADDR_PWR_DOWN: read_mux = r.pwr_down;
            `RPM_ADDR_RSV_16:   read_mux = r.rsv_16;
            `RPM_ADDR_RSV_17:   read_mux = r.rsv_17;
            `RPM_ADDR_SEC_SEL:  read_mux = r.sec_sel;
            `RPM_ADDR_RSV_19:   read_mux = r.rsv_19;
            `RPM_ADDR_RSV_1A:   read_mux = r.rsv_1a;
            `RPM_ADDR_RSV_1B:   read_mux = r.rsv_1b;
            `RPM_ADDR_RATE_SEL: read_mux = r.rate_sel;
            default:            read_mux = `RPM_UNMAPPED_DATA;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_regs        = regs_ff;
        nxt_regs.rvalid = reg_read;
        if (reg_read) begin
            nxt_regs.rdata = read_mux(regs_ff, reg_addr);
        end
        if (reg_write) begin
            case (reg_addr)
                `RPM_ADDR_PWR_DOWN: nxt_regs.pwr_down = reg_wdata;
                `RPM_ADDR_RSV_16:   nxt_regs.rsv_16   = reg_wdata;
                `RPM_ADDR_RSV_17:   nxt_regs.rsv_17   = reg_wdata;
                `RPM_ADDR_SEC_SEL:  nxt_regs.sec_sel  = reg_wdata;
                `RPM_ADDR_RSV_19:   nxt_regs.rsv_19   = reg_wdata;
                `RPM_ADDR_RSV_1A:   nxt_regs.rsv_1a   = reg_wdata;
                `RPM_ADDR_RSV_1B:   nxt_regs.rsv_1b   = reg_wdata;
                `RPM_ADDR_RATE_SEL: nxt_regs.rate_sel = reg_wdata;
                default:            nxt_regs.rvalid   = reg_read;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            regs_ff.pwr_down <= `RPM_RST_PWR_DOWN;
            regs_ff.rsv_16   <= `RPM_RST_RSV_16;
            regs_ff.rsv_17   <= `RPM_RST_RSV_17;
            regs_ff.sec_sel  <= `RPM_RST_SEC_SEL;
            regs_ff.rsv_19   <= `RPM_RST_RSV_19;
            regs_ff.rsv_1a   <= `RPM_RST_RSV_1A;
            regs_ff.rsv_1b   <= `RPM_RST_RSV_1B;
            regs_ff.rate_sel <= `RPM_RST_RATE_SEL;
            regs_ff.rdata    <= `RPM_UNMAPPED_DATA;
            regs_ff.rvalid   <= 1'b0;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign reg_rdata  = regs_ff.rdata;
    assign reg_rvalid = regs_ff.rvalid;

    assign equalizer_power_down = regs_ff.pwr_down[`RPM_EQ_PD_LSB +: 4];
    assign detector_power_down  = regs_ff.pwr_down[`RPM_DET_PD_LSB +: 4];
    // Detector output is meaningless once its bias is removed
    assign signal_present = detector_signal_raw & ~detector_power_down;
    assign line_rate_code = regs_ff.rate_sel[`RPM_RATE_LSB +: 2];

    assign route_bus.secondary_channel_select   = regs_ff.sec_sel[`RPM_SEC_SEL_LSB +: 2];
    assign route_bus.secondary_select_override  = secondary_select_override;
    assign route_bus.primary_channel_select     = primary_channel_select;
    assign route_bus.secondary_equalized_choice = secondary_equalized_choice;

    rpm_route u_route (
        .clock (clock),
        .reset (reset),
        .rif   (route_bus.router)
    );

    // Both consumers share one selection, so they can never disagree
    assign eye_monitor_channel            = route_bus.routed_channel;
    assign serial_output_1_bypass_channel = route_bus.routed_channel;
    assign secondary_use_equalized        = route_bus.routed_equalized;

    ////////////////////////////////////////////////////////////////////////////
    AST_DET1_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> detector_power_down[1] == $past(reg_wdata[5]))
    else $error("input 1 detector power down not taken from bit 5");

    AST_DET0_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> detector_power_down[0] == $past(reg_wdata[4]))
    else $error("input 0 detector power down not taken from bit 4");

    AST_EQ3_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> equalizer_power_down[3] == $past(reg_wdata[3]))
    else $error("input 3 equalizer power down not taken from bit 3");

    AST_EQ2_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> equalizer_power_down[2] == $past(reg_wdata[2]))
    else $error("input 2 equalizer power down not taken from bit 2");

    AST_EQ1_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> equalizer_power_down[1] == $past(reg_wdata[1]))
    else $error("input 1 equalizer power down not taken from bit 1");

    AST_EQ0_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> equalizer_power_down[0] == $past(reg_wdata[0]))
    else $error("input 0 equalizer power down not taken from bit 0");

    AST_PD_RESET:
    assert property (@(posedge clock)
        reset |=> equalizer_power_down == 4'h0 && detector_power_down == 4'h0)
    else $error("power down bits not cleared by reset");

    AST_SEC_READBACK:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_SEC_SEL
        ##1 reg_read && reg_addr == `RPM_ADDR_SEC_SEL && !reg_write
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("secondary select register did not read back as written");

    AST_DET_HIGH_PD:
    assert property (@(posedge clock) disable iff (reset)
        reg_write && reg_addr == `RPM_ADDR_PWR_DOWN
        |=> detector_power_down[3:2] == $past(reg_wdata[7:6]))
    else $error("input 3 and 2 detector power down not taken from bits 7 and 6");

    AST_PRESENT_GATED:
    assert property (@(posedge clock) disable iff (reset)
        detector_power_down != 4'h0 |-> (signal_present & detector_power_down) == 4'h0)
    else $error("signal present seen from a powered down detector");

    AST_OVERRIDE_PATH:
    assert property (@(posedge clock) disable iff (reset)
        secondary_select_override && !reg_write
        |=> eye_monitor_channel == $past(regs_ff.sec_sel[1:0]))
    else $error("eye monitor channel does not follow secondary select");

endmodule // rpm_top

`default_nettype wire

//--- bench/tb_rpm_top.sv
// Self-checking testbench for the receiver power and secondary mux register bank
`timescale 1ns/1ps
`include "rpm_defines.svh"
`default_nettype none

module tb_rpm_top;
    logic       clock;
    logic       reset;
    logic       reg_write;
    logic       reg_read;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rvalid;
    logic       override;
    logic       eq_choice;
    logic [1:0] primary;
    logic [3:0] raw;
    logic [3:0] eq_pd;
    logic [3:0] det_pd;
    logic [3:0] sig_present;
    logic [1:0] eye_ch;
    logic [1:0] bypass_ch;
    logic       use_eq;
    logic [1:0] rate_code;
    logic [7:0] exp_q[$];
    logic [7:0] wvals[8];
    integer     seed = 32'h9657;
    integer     miscompares = 0;
    integer     checks_done = 0;

    rpm_top i_dut (
        .clock(clock), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .secondary_select_override(override),
        .secondary_equalized_choice(eq_choice), .primary_channel_select(primary),
        .detector_signal_raw(raw), .equalizer_power_down(eq_pd),
        .detector_power_down(det_pd), .signal_present(sig_present),
        .eye_monitor_channel(eye_ch), .serial_output_1_bypass_channel(bypass_ch),
        .secondary_use_equalized(use_eq), .line_rate_code(rate_code)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Write strobe stays one cycle so each call is exactly one transfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    // Read data scoreboard: oldest note against each valid answer
    always @(posedge clock) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(reg_rdata, 8'hXX);
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic [7:0] rst_tab[8];
        integer     i;
        rst_tab = '{`RPM_RST_PWR_DOWN, `RPM_RST_RSV_16, `RPM_RST_RSV_17, `RPM_RST_SEC_SEL,
                    `RPM_RST_RSV_19, `RPM_RST_RSV_1A, `RPM_RST_RSV_1B, `RPM_RST_RATE_SEL};
        reset = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        override = 1'b0;
        eq_choice = 1'b0;
        primary = 2'h0;
        raw = 4'hF;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        // Choice input held low so only the reset value can show a one here
        #1 check({7'h00, use_eq}, {7'h00, `RPM_EQ_CHOICE_RST});
        for (i = 0; i < 8; i++) rd(8'h15 + i[7:0], rst_tab[i]);
        #1 check({4'h0, sig_present}, 8'h0F);
        check({6'h00, eye_ch}, 8'h00);
        for (i = 0; i < 8; i++) begin
            wvals[i] = $random(seed);
            wr(8'h15 + i[7:0], wvals[i]);
            rd(8'h15 + i[7:0], wvals[i]);
        end
        #1 check({6'h00, rate_code}, {6'h00, wvals[7][1:0]});
        // Unmapped offsets: writes dropped, reads give zero
        wr(8'h1D, 8'hFF);
        rd(8'h1D, `RPM_UNMAPPED_DATA);
        rd(8'h14, `RPM_UNMAPPED_DATA);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(`RPM_ADDR_PWR_DOWN, d);
            raw <= $random(seed);
            #1 check({4'h0, eq_pd}, {4'h0, d[3:0]});
            check({4'h0, det_pd}, {4'h0, d[7:4]});
            check({4'h0, sig_present}, {4'h0, raw & ~d[7:4]});
        end
        override <= 1'b1;
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            d[1:0] = i[1:0];
            wr(`RPM_ADDR_SEC_SEL, d);
            @(posedge clock);
            #1 check({6'h00, eye_ch}, {6'h00, i[1:0]});
            check({6'h00, bypass_ch}, {6'h00, i[1:0]});
            rd(`RPM_ADDR_SEC_SEL, d);
        end
        // Secondary field now holds 3; clear override so primary must win
        @(posedge clock);
        override <= 1'b0;
        for (i = 0; i < 4; i++) begin
            @(posedge clock);
            primary <= i[1:0];
            eq_choice <= i[0];
            @(posedge clock);
            #1 check({6'h00, eye_ch}, {6'h00, i[1:0]});
            check({6'h00, bypass_ch}, {6'h00, i[1:0]});
            check({7'h00, use_eq}, {7'h00, i[0]});
        end
        // Read and write in one cycle: read returns the old value
        @(posedge clock);
        reg_addr <= `RPM_ADDR_RSV_19;
        reg_wdata <= 8'h5A;
        reg_write <= 1'b1;
        reg_read <= 1'b1;
        exp_q.push_back(wvals[4]);
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b0;
        rd(`RPM_ADDR_RSV_19, 8'h5A);
        rd(`RPM_ADDR_RSV_19, 8'h5A);
        // Write then read back at the very next edge, no idle cycle between
        d = $random(seed);
        @(posedge clock);
        reg_addr <= `RPM_ADDR_SEC_SEL;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        exp_q.push_back(d);
        @(posedge clock);
        reg_read <= 1'b0;
        for (i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clock);
        if (exp_q.size() != 0) miscompares++;
        finish_test();
    end
endmodule // tb_rpm_top

`default_nettype wire
